/* File: inc/ucs_pkg.sv */
// Constants, register map and state types of the serial control and status block
// Notes on behaviour
// RULE_01 - Transmit-empty interrupt follows its enable bit
// RULE_02 - Transmit-done interrupt follows its enable bit
// RULE_03 - Receive-full interrupt follows its enable bit
// RULE_04 - Line-quiet interrupt follows its enable bit
// RULE_05 - Transmitter runs and owns pin when enabled
// RULE_06 - Single-wire direction bit steers the transmit pin
// RULE_07 - Enable off then on queues one idle
// RULE_08 - Pin held until pending traffic finishes
// RULE_09 - Receiver enable; receive pin released when off
// RULE_10 - Loop select releases receive pin always
// RULE_11 - Standby set by software, cleared on wakeup
// RULE_12 - Wakeup by quiet line or data MSB
// RULE_13 - Break bit one-then-zero sends one break
// RULE_14 - Breaks repeat while bit held, 10/13 bits
// RULE_15 - A second break may be queued
// RULE_16 - Control two accessible at any time
// RULE_17 - Status flags read-only, writes ignored
// RULE_18 - Empty flag set on shifter load, sequence-cleared
// RULE_19 - Full flag set on receive, sequence-cleared
// RULE_20 - Loop select connects transmitter to receiver
// RULE_21 - One interrupt line from enabled flags
package ucs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  // Control one fields
  localparam int LOOP_BIT = 7;
  localparam int RX_SRC_BIT = 5;
  localparam int WAKE_BIT = 3;
  localparam int LONG_BRK_BIT = 2;
  localparam int DIR_BIT = 1;
  localparam logic [7:0] CTRL_ONE_MASK = 8'hAE;
  // Control two fields
  localparam int TXIE_BIT = 7;
  localparam int RXIE_BIT = 4;
  localparam int TX_ON_BIT = 3;
  localparam int RX_ON_BIT = 2;
  localparam int STANDBY_BIT = 1;
  localparam int BRK_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status one fields
  localparam int TX_EMPTY_BIT = 7;
  localparam int TX_DONE_BIT = 6;
  localparam int RX_FULL_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int OVR_BIT = 3;
  // Character lengths in bit times
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam logic [3:0] LONG_BREAK_BITS = 4'hD;
  localparam logic [3:0] IDLE_BITS = 4'hA;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam int DEF_CYCLES_PER_BIT = 16;
  // Edges from a bit timer reaching zero to its tick being used
  localparam int TIMER_LAG = 2;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} ucs_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} ucs_rx_e;
endpackage

/* File: src/ucs_bit_timer.sv */
// Bit-time tick generator; the transmit and receive paths each have their own instance
`timescale 1ns/1ps
module ucs_bit_timer #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic run,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] first,
  output logic tick
);
  logic [W-1:0] cnt_reg;

  // Restart loads a first delay so the receiver can land mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_reg <= first;
      tick <= 1'b0;
    end else if (run && cnt_reg == '0) begin
      cnt_reg <= period - W'(1);
      tick <= 1'b1;
    end else begin
      cnt_reg <= run ? cnt_reg - W'(1) : cnt_reg;
      tick <= 1'b0;
    end
  end
endmodule // ucs_bit_timer

/* File: src/ucs_serial_ctrl.sv */
// Serial unit: control two, status one, transmit and receive paths, APB slave
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ucs_serial_ctrl import ucs_pkg::*; #(
  parameter int CYCLES_PER_BIT = DEF_CYCLES_PER_BIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rx_pin_used,
  output logic irq
);
  localparam logic [15:0] PERIOD = 16'(CYCLES_PER_BIT);
  // Mid-bit sampling needs the tick lag taken off; needs four or more cycles per bit
  localparam logic [15:0] HALF = 16'(CYCLES_PER_BIT / 2 - TIMER_LAG);
  localparam logic [15:0] IDLE_CYC = 16'(int'(IDLE_BITS) * CYCLES_PER_BIT);

  logic [7:0] ctrl_one_reg, serial_control_two_reg;
  logic [7:0] tx_buf_reg, rx_data_reg, rx_sh_reg;
  logic tx_buffer_empty_reg, tx_done_flag_reg, rx_buffer_full_reg, idle_reg, ovr_reg;
  logic arm_empty_reg, arm_done_reg, arm_full_reg, arm_idle_reg, arm_ovr_reg;
  logic break_pend_reg, idle_pend_reg, idle_armed_reg;
  logic [15:0] tx_sh_reg, idle_cnt_reg;
  logic [3:0] tx_left_reg;
  logic [2:0] rx_cnt_reg;
  ucs_tx_e tx_state_reg;
  ucs_rx_e rx_state_reg;
  logic tx_tick, rx_tick;

  // Register decode: an access completes on the edge where pready is high
  wire acc = psel & penable & pready;
  wire hit_c1 = paddr == ADDR_CTRL_ONE;
  wire hit_c2 = paddr == ADDR_CTRL_TWO;
  wire hit_st = paddr == ADDR_STATUS_ONE;
  wire hit_dt = paddr == ADDR_DATA;
  wire mapped = hit_c1 | hit_c2 | hit_st | hit_dt;
  wire wr_c1 = acc & pwrite & hit_c1;
  wire wr_c2 = acc & pwrite & hit_c2; // see RULE_16
  wire rd_st = acc & ~pwrite & hit_st;
  wire wr_dt = acc & pwrite & hit_dt;
  wire rd_dt = acc & ~pwrite & hit_dt;

  // Control field views
  wire loop_select = ctrl_one_reg[LOOP_BIT];
  wire rx_source_sel = ctrl_one_reg[RX_SRC_BIT];
  wire wake_method = ctrl_one_reg[WAKE_BIT];
  wire long_break_sel = ctrl_one_reg[LONG_BRK_BIT];
  wire single_wire_dir = ctrl_one_reg[DIR_BIT];
  wire tx_on = serial_control_two_reg[TX_ON_BIT];
  wire rx_on = serial_control_two_reg[RX_ON_BIT];
  wire rx_standby = serial_control_two_reg[STANDBY_BIT];
  wire break_queue = serial_control_two_reg[BRK_BIT];
  wire [7:0] serial_status_one = {tx_buffer_empty_reg, tx_done_flag_reg, rx_buffer_full_reg,
                                  idle_reg, ovr_reg, 3'h0};

  // Software events on control two
  wire tx_on_rise = wr_c2 & pwdata[TX_ON_BIT] & ~tx_on; // see RULE_07
  wire brk_write = wr_c2 & pwdata[BRK_BIT]; // see RULE_13

  // Transmit loader: break first, then queued idle, then buffered data
  wire tx_free = tx_state_reg == TX_IDLE;
  wire want_brk = break_pend_reg | break_queue; // see RULE_14
  wire ld_brk = tx_free & want_brk;
  wire ld_idle = tx_free & ~want_brk & idle_pend_reg;
  wire ld_data = tx_free & ~want_brk & ~idle_pend_reg & tx_on & ~tx_buffer_empty_reg; // see RULE_05
  wire tx_load = ld_brk | ld_idle | ld_data;
  wire tx_end = ~tx_free & tx_tick & (tx_left_reg == 4'h1);
  wire tx_line = tx_free ? 1'b1 : tx_sh_reg[0];
  wire [3:0] brk_len = long_break_sel ? LONG_BREAK_BITS : BREAK_BITS;
  wire tx_pending = want_brk | idle_pend_reg;
  wire tx_owner = tx_on | ~tx_free | tx_pending; // see RULE_08
  wire single_wire = loop_select & rx_source_sel;
  wire tx_drive = tx_owner & (~single_wire | single_wire_dir); // see RULE_06
  wire done_set = tx_end & tx_buffer_empty_reg & ~tx_pending;

  // Receive source: pin, internal loop or the shared single wire
  wire rx_line = loop_select ? (rx_source_sel ? txd_in : tx_line) : rxd_in; // see RULE_20
  wire rx_done = (rx_state_reg == RX_STOP) & rx_tick;
  wire addr_mark = wake_method & rx_sh_reg[LAST_DATA_BIT];
  wire rx_keep = rx_done & (~rx_standby | addr_mark);
  wire idle_hit = rx_on & (rx_state_reg == RX_IDLE) & rx_line & (idle_cnt_reg == IDLE_CYC - 16'h1);
  wire wake_now = rx_standby & ((~wake_method & idle_hit) | (rx_done & addr_mark)); // see RULE_12

  // Sequence clears: status read arms, then a data access finishes them; transmit-done also by an enable rise or a break write
  wire clr_empty = wr_dt & arm_empty_reg;
  wire clr_done = arm_done_reg & (wr_dt | tx_on_rise | brk_write);
  wire clr_rx = rd_dt;

  // Bit timers for each direction
  ucs_bit_timer #(.W(16)) u_tx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(tx_load),
    .run(~tx_free),
    .period(PERIOD),
    .first(PERIOD - 16'(TIMER_LAG)),
    .tick(tx_tick)
  );

  ucs_bit_timer #(.W(16)) u_rx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(rx_state_reg == RX_IDLE),
    .run(rx_state_reg != RX_IDLE),
    .period(PERIOD),
    .first(HALF),
    .tick(rx_tick)
  );

  // APB slave: one wait state, so pready and prdata come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= hit_c1 ? {24'h0, ctrl_one_reg} :
                  hit_c2 ? {24'h0, serial_control_two_reg} :
                  hit_st ? {24'h0, serial_status_one} :
                  hit_dt ? {24'h0, rx_data_reg} : 32'h0;
      end
    end
  end

  // Control registers; standby write wins over a wakeup in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_reg <= CTRL_RESET;
      serial_control_two_reg <= CTRL_RESET;
    end else begin
      if (wr_c1) begin
        ctrl_one_reg <= pwdata[7:0] & CTRL_ONE_MASK;
      end
      if (wr_c2) begin
        serial_control_two_reg <= pwdata[7:0]; // see RULE_11
      end else if (wake_now) begin
        serial_control_two_reg[STANDBY_BIT] <= 1'b0; // see RULE_11
      end
    end
  end

  // Queued break and idle requests; a one-then-zero pulse still sends one break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_pend_reg <= 1'b0;
      idle_pend_reg <= 1'b0;
    end else begin
      if (brk_write) begin
        break_pend_reg <= 1'b1; // see RULE_13
      end else if (ld_brk) begin
        break_pend_reg <= 1'b0; // see RULE_15
      end
      if (tx_on_rise) begin
        idle_pend_reg <= 1'b1; // see RULE_07
      end else if (ld_idle) begin
        idle_pend_reg <= 1'b0;
      end
    end
  end

  // Transmit shifter; line rests high between characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 16'hFFFF;
      tx_left_reg <= 4'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (ld_brk) begin
            tx_sh_reg <= 16'h0000; // see RULE_14
            tx_left_reg <= brk_len;
            tx_state_reg <= TX_SHIFT;
          end else if (ld_idle) begin
            tx_sh_reg <= 16'hFFFF;
            tx_left_reg <= IDLE_BITS;
            tx_state_reg <= TX_SHIFT;
          end else if (ld_data) begin
            tx_sh_reg <= {6'h3F, 1'b1, tx_buf_reg, 1'b0};
            tx_left_reg <= FRAME_BITS;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[15:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            if (tx_end) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Transmit buffer and its flags; hardware set beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_reg <= 8'h00;
      tx_buffer_empty_reg <= 1'b1;
      tx_done_flag_reg <= 1'b1;
    end else begin
      if (wr_dt) begin
        tx_buf_reg <= pwdata[7:0];
      end
      if (ld_data) begin
        tx_buffer_empty_reg <= 1'b1; // see RULE_18
      end else if (clr_empty) begin
        tx_buffer_empty_reg <= 1'b0; // see RULE_18
      end
      if (done_set) begin
        tx_done_flag_reg <= 1'b1;
      end else if (clr_done) begin
        tx_done_flag_reg <= 1'b0;
      end
    end
  end

  // Status read snapshot arms the clear sequences; writes to status do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_empty_reg <= 1'b0;
      arm_done_reg <= 1'b0;
      arm_full_reg <= 1'b0;
      arm_idle_reg <= 1'b0;
      arm_ovr_reg <= 1'b0;
    end else if (rd_st) begin
      arm_empty_reg <= tx_buffer_empty_reg; // see RULE_17
      arm_done_reg <= tx_done_flag_reg;
      arm_full_reg <= rx_buffer_full_reg;
      arm_idle_reg <= idle_reg;
      arm_ovr_reg <= ovr_reg;
    end else begin
      arm_empty_reg <= arm_empty_reg & ~wr_dt;
      arm_done_reg <= arm_done_reg & ~clr_done;
      arm_full_reg <= arm_full_reg & ~rd_dt;
      arm_idle_reg <= arm_idle_reg & ~rd_dt;
      arm_ovr_reg <= arm_ovr_reg & ~rd_dt;
    end
  end

  // Receive framer: start check at mid-bit, eight data bits LSB first, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 3'h0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_on & ~rx_line) begin
            rx_state_reg <= RX_START; // see RULE_09
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_reg <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == LAST_DATA_BIT) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Quiet-line timer counts line-high cycles while the receiver waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg <= 16'h0;
    end else if (~rx_on | (rx_state_reg != RX_IDLE) | ~rx_line) begin
      idle_cnt_reg <= 16'h0;
    end else if (idle_cnt_reg != IDLE_CYC) begin
      idle_cnt_reg <= idle_cnt_reg + 16'h1;
    end
  end

  // Receive flags; a character read in standby without a mark is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg <= 8'h00;
      rx_buffer_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      idle_reg <= 1'b0;
      idle_armed_reg <= 1'b0;
    end else begin
      if (rx_keep & ~rx_buffer_full_reg) begin
        rx_data_reg <= rx_sh_reg;
      end
      if (rx_keep & ~rx_buffer_full_reg) begin
        rx_buffer_full_reg <= 1'b1; // see RULE_19
      end else if (clr_rx & arm_full_reg) begin
        rx_buffer_full_reg <= 1'b0; // see RULE_19
      end
      if (rx_keep & rx_buffer_full_reg) begin
        ovr_reg <= 1'b1;
      end else if (clr_rx & arm_ovr_reg) begin
        ovr_reg <= 1'b0;
      end
      // Quiet flag sets once per received character, not again until new data
      if (idle_hit & idle_armed_reg & ~rx_standby) begin
        idle_reg <= 1'b1;
      end else if (clr_rx & arm_idle_reg) begin
        idle_reg <= 1'b0;
      end
      if (rx_keep) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_hit & ~rx_standby) begin
        idle_armed_reg <= 1'b0;
      end
    end
  end

  // Pin ownership, line level and the single interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
      rx_pin_used <= 1'b0;
      irq <= 1'b0;
    end else begin
      txd_out <= tx_line;
      txd_oe <= tx_drive; // see RULE_05
      rx_pin_used <= rx_on & ~loop_select; // see RULE_09 see RULE_10
      irq <= (serial_control_two_reg[TXIE_BIT] & tx_buffer_empty_reg) | // see RULE_01
             (serial_control_two_reg[TXIE_BIT - 1] & tx_done_flag_reg) | // see RULE_02
             (serial_control_two_reg[RXIE_BIT + 1] & rx_buffer_full_reg) | // see RULE_03
             (serial_control_two_reg[RXIE_BIT] & idle_reg); // see RULE_04 see RULE_21
    end
  end
endmodule // ucs_serial_ctrl

/* File: tb/ucs_serial_ctrl_properties.sv */
// Checker of bus timing, pin ownership, interrupt and line timing of the serial unit
`timescale 1ns/1ps
module ucs_chk import ucs_pkg::*; #(
  parameter int CYCLES_PER_BIT = DEF_CYCLES_PER_BIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd_in,
  input wire logic txd_in,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rx_pin_used,
  input wire logic irq
);
  logic wr_ev;
  logic own_rx;
  logic lone_in;
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;
  logic [8:0] low_reg;
  // Decoded views of the shadowed control bits
  assign wr_ev = psel & penable & pready & pwrite;
  assign own_rx = c2_reg[RX_ON_BIT] & ~c1_reg[LOOP_BIT];
  assign lone_in = c1_reg[LOOP_BIT] & c1_reg[RX_SRC_BIT] & ~c1_reg[DIR_BIT];
  // Shadow of both control registers, taken from completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_reg <= 8'h00;
      c2_reg <= 8'h00;
    end else if (wr_ev && paddr == ADDR_CTRL_ONE) begin
      c1_reg <= pwdata[7:0];
    end else if (wr_ev && paddr == ADDR_CTRL_TWO) begin
      c2_reg <= pwdata[7:0];
    end
  end
  // Length of the present low stretch on the transmit line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg <= 9'h000;
    end else begin
      low_reg <= txd_out ? 9'h000 : low_reg + 9'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  wait_state_a: assert property (setup_s |=> access_s) else $error("pready not after one wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than a cycle");
  err_map_a: assert property (pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  status_ro_a: assert property (wr_ev && paddr == ADDR_STATUS_ONE |-> !pslverr)
    else $error("status write flagged");
  rx_pin_a: assert property (own_rx == $past(own_rx) |-> rx_pin_used == own_rx)
    else $error("receive pin ownership wrong");
  tx_pin_a: assert property (c2_reg[TX_ON_BIT] && $past(c2_reg[TX_ON_BIT]) && !c1_reg[LOOP_BIT] |-> txd_oe)
    else $error("transmit pin not driven");
  lone_dir_a: assert property (lone_in && $past(lone_in) |-> !txd_oe)
    else $error("single wire driven while inbound");
  quiet_irq_a: assert property (c2_reg == 8'h00 && $past(c2_reg) == 8'h00 |-> !irq)
    else $error("irq without enable");
  low_len_a: assert property ($rose(txd_out) |-> low_reg % CYCLES_PER_BIT == 0)
    else $error("low stretch not whole bits");
endmodule // ucs_chk
bind ucs_serial_ctrl ucs_chk #(.CYCLES_PER_BIT(CYCLES_PER_BIT)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .txd_in(txd_in), .txd_out(txd_out),
  .txd_oe(txd_oe), .rx_pin_used(rx_pin_used), .irq(irq));

/* File: tb/ucs_remote_node.sv */
// Remote serial node: sends frames on the receive pin and decodes the transmit pin
`timescale 1ns/1ps
module ucs_remote_node #(
  parameter int CPB = 4
) (
  input wire logic pclk,
  input wire logic txd_line,
  output logic rxd_line,
  output logic [7:0] got_byte,
  output int got_cnt,
  output int last_low
);
  int low_run = 0;
  initial begin
    rxd_line = 1'b1;
    got_byte = 8'h00;
    got_cnt = 0;
    last_low = 0;
  end
  // Start low, eight data bits LSB first, stop high; line rests high after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd_line <= f[i];
      repeat (CPB - 1) @(posedge pclk);
    end
  endtask
  // Falling-edge sampling keeps clear of the unit's launch edge
  always @(negedge pclk) begin
    if (txd_line === 1'b0) begin
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  // Frame decoder; a break also decodes, as zero, and is ignored by users
  always begin
    @(negedge pclk iff txd_line === 1'b0);
    repeat (CPB / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (CPB) @(negedge pclk);
      got_byte[i] = txd_line;
    end
    repeat (CPB) @(negedge pclk);
    got_cnt = got_cnt + 1;
  end
endmodule // ucs_remote_node

/* File: tb/uart_control_two_and_status_access_tb_top.sv */
// Testbench: registers, interrupts, transmit, receive, loop, break and standby
`timescale 1ns/1ps
module uart_control_two_and_status_access_tb_top import ucs_pkg::*;;
  localparam int CPB = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, txd_out, txd_oe, rx_pin_used, irq, rxd_in, txd_line, e;
  logic [7:0] got_byte;
  int got_cnt, last_low;
  int fail_count = 0;
  int cmp_count = 0;
  always #4 pclk = ~pclk;
  // Transmit pin is pulled up while nobody drives it
  assign txd_line = txd_oe ? txd_out : 1'b1;
  ucs_serial_ctrl #(.CYCLES_PER_BIT(CPB)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_in(rxd_in), .txd_in(txd_line), .txd_out(txd_out), .txd_oe(txd_oe),
    .rx_pin_used(rx_pin_used), .irq(irq));
  ucs_remote_node #(.CPB(CPB)) i_node (.pclk(pclk), .txd_line(txd_line), .rxd_line(rxd_in),
    .got_byte(got_byte), .got_cnt(got_cnt), .last_low(last_low));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, entered just after a rising edge; waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 0, 1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(0, ADDR_CTRL_TWO, 0);
    chk("ctrl2", q, 32'h0);
    apb(0, ADDR_STATUS_ONE, 0);
    chk("status", q, 32'hC0);
  endtask
  task automatic t_irq();
    logic [7:0] en [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
    logic xp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CTRL_TWO, {24'h0, en[i]});
      cyc(2);
      chk("irq", 32'(irq), 32'(xp[i]));
    end
  endtask
  task automatic t_regs();
    apb(1, ADDR_STATUS_ONE, 0);
    chk("status err", 32'(e), 0);
    apb(0, ADDR_STATUS_ONE, 0);
    chk("status", q, 32'hC0);
    apb(0, 8'h20, 0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1, ADDR_CTRL_TWO, 32'hFF30);
    apb(0, ADDR_CTRL_TWO, 0);
    chk("ctrl2", q, 32'h30);
  endtask
  task automatic t_tx();
    int n0;
    n0 = got_cnt;
    apb(1, ADDR_CTRL_TWO, 32'h08);
    apb(0, ADDR_STATUS_ONE, 0);
    apb(1, ADDR_DATA, 32'hA5);
    // Let the queued idle drain so the byte is shifting when the enable drops
    cyc(11 * CPB);
    apb(1, ADDR_CTRL_TWO, 32'h00);
    chk("oe held", 32'(txd_oe), 1);
    for (int i = 0; i < 20 * CPB && got_cnt == n0; i++) cyc(1);
    chk("tx byte", 32'(got_byte), 32'hA5);
    cyc(3 * CPB);
    chk("oe off", 32'(txd_oe), 0);
    apb(0, ADDR_STATUS_ONE, 0);
    chk("status", q, 32'hC0);
  endtask
  task automatic t_rx();
    apb(1, ADDR_CTRL_TWO, 32'h24);
    cyc(1);
    chk("rx pin", 32'(rx_pin_used), 1);
    i_node.send(8'h3C);
    cyc(2 * CPB);
    chk("irq full", 32'(irq), 1);
    apb(0, ADDR_STATUS_ONE, 0);
    chk("status", q, 32'hE0);
    apb(0, ADDR_DATA, 0);
    chk("rx byte", q, 32'h3C);
    apb(1, ADDR_CTRL_TWO, 32'h14);
    cyc(12 * CPB);
    chk("irq quiet", 32'(irq), 1);
    apb(0, ADDR_STATUS_ONE, 0);
    chk("status", q, 32'hD0);
    apb(0, ADDR_DATA, 0);
    cyc(2);
    chk("irq clear", 32'(irq), 0);
  endtask
  task automatic t_loop();
    apb(1, ADDR_CTRL_TWO, 32'h0C);
    apb(1, ADDR_CTRL_ONE, 32'hA0);
    cyc(2);
    chk("oe inbound", 32'(txd_oe), 0);
    chk("rx pin", 32'(rx_pin_used), 0);
    apb(1, ADDR_CTRL_ONE, 32'hA2);
    cyc(1);
    chk("oe outbound", 32'(txd_oe), 1);
    apb(1, ADDR_CTRL_ONE, 32'h80);
    apb(0, ADDR_STATUS_ONE, 0);
    apb(1, ADDR_DATA, 32'h5A);
    cyc(16 * CPB);
    apb(0, ADDR_STATUS_ONE, 0);
    apb(0, ADDR_DATA, 0);
    chk("loop byte", q, 32'h5A);
    apb(1, ADDR_CTRL_ONE, 32'h00);
  endtask
  task automatic t_break();
    int b;
    for (int i = 0; i < 2; i++) begin
      b = i ? 13 * CPB : 10 * CPB;
      apb(1, ADDR_CTRL_ONE, i ? 32'h04 : 32'h00);
      apb(1, ADDR_CTRL_TWO, 32'h09);
      apb(1, ADDR_CTRL_TWO, 32'h08);
      cyc(30 * CPB);
      chk("break", 32'(last_low == b || last_low == 2 * b), 1);
    end
    apb(1, ADDR_CTRL_ONE, 32'h00);
  endtask
  task automatic t_standby();
    apb(1, ADDR_CTRL_ONE, 32'h08);
    apb(1, ADDR_CTRL_TWO, 32'h06);
    i_node.send(8'h12);
    cyc(2 * CPB);
    apb(0, ADDR_CTRL_TWO, 0);
    chk("standby kept", q, 32'h06);
    i_node.send(8'h92);
    cyc(2 * CPB);
    apb(0, ADDR_CTRL_TWO, 0);
    chk("standby woke", q, 32'h04);
    // Quiet-line wakeup: standby is set well before the line has been high a full character
    apb(1, ADDR_CTRL_ONE, 32'h00);
    apb(1, ADDR_CTRL_TWO, 32'h06);
    cyc(12 * CPB);
    apb(0, ADDR_CTRL_TWO, 0);
    chk("standby quiet", q, 32'h04);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_irq();
    t_regs();
    t_tx();
    t_rx();
    t_loop();
    t_break();
    t_standby();
    report_and_stop();
  end
  // Watchdog well beyond the under a thousand cycles the sequence needs
  initial begin
    cyc(20000);
    fail_count++;
    report_and_stop();
  end
endmodule // uart_control_two_and_status_access_tb_top
